// ==== rtl/line_status_regs.vh ====
// Constants for the serial line status logic: bits, tags, depths, states
`ifndef LINE_STATUS_REGS_VH
`define LINE_STATUS_REGS_VH

// Line status word bit positions
`define LS_DATA_AVAIL   0
`define LS_OVERRUN      1
`define LS_PARITY       2
`define LS_FRAMING      3
`define LS_BREAK        4
`define LS_TX_FIFO_MT   5
`define LS_TX_IDLE      6
`define LS_RX_ERR_ANY   7
`define LS_WIDTH        8
`define LS_RESET        8'h60

// Receive FIFO entry: data byte plus three tag bits
`define ENTRY_W         11
`define TAG_PARITY      8
`define TAG_FRAMING     9
`define TAG_BREAK       10
`define RXF_DEPTH       16
`define RXF_AW          4
`define RXF_CW          5
`define RXF_FULL        5'h10

// Oversampling: sixteen ticks a bit, start checked at the middle
`define OS_MID          4'h7
`define OS_LAST         4'hf
`define MIN_BITS        4'h5

// Receiver states
`define RX_IDLE         3'h0
`define RX_START        3'h1
`define RX_DATA         3'h2
`define RX_PARITY       3'h3
`define RX_STOP         3'h4
`define RX_WAIT_HIGH    3'h5

`endif

// ==== rtl/rx_skid_buffer.v ====
// Two-entry buffer between the receiver and the receive FIFO
`timescale 1ns/1ps
`include "line_status_regs.vh"
module rx_skid_buffer (
	input  wire                clk_i,       // Core clock
	input  wire                rst_i,       // Async reset, active high
	input  wire                ce_i,        // Clock enable
	input  wire                flush_i,     // Drop both entries
	input  wire                in_valid_i,  // Entry offered
	output wire                in_ready_o,  // Room for an entry
	input  wire [`ENTRY_W-1:0] in_data_i,   // Entry in
	output wire                out_valid_o, // Entry held
	input  wire                out_ready_i, // Drain side takes it
	output reg  [`ENTRY_W-1:0] out_data_o   // Oldest entry
);
	reg  [`ENTRY_W-1:0] second;
	reg  [1:0]          fill;
	wire                take;
	wire                give;

	assign in_ready_o  = (fill != 2'h2);
	assign out_valid_o = (fill != 2'h0);
	assign take        = in_valid_i & in_ready_o;
	assign give        = out_valid_o & out_ready_i;

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			fill       <= 2'h0;
			out_data_o <= {`ENTRY_W{1'b0}};
			second     <= {`ENTRY_W{1'b0}};
		end else if (ce_i) begin
			if (flush_i) begin
				fill <= 2'h0;
			end else begin
				case ({take, give})
				2'b10: begin
					if (fill == 2'h0)
						out_data_o <= in_data_i;
					else
						second <= in_data_i;
					fill <= fill + 2'h1;
				end
				2'b01: begin
					out_data_o <= second;
					fill       <= fill - 2'h1;
				end
				2'b11: begin
					// Full never gets here since take needs room
					if (fill == 2'h1)
						out_data_o <= in_data_i;
					else begin
						out_data_o <= second;
						second     <= in_data_i;
					end
				end
				default: fill <= fill;
				endcase
			end
		end
	end
endmodule // rx_skid_buffer

// ==== rtl/line_status.v ====
// Serial receiver, tagged receive FIFO and line status word
`timescale 1ns/1ps
`include "line_status_regs.vh"
// Function
// - Bit 0 high while receive FIFO holds any character.
// - Bit 1 set when a completed character finds the FIFO and both skid buffer entries full.
// - On overrun the shift register is overwritten, FIFO left intact.
// - Bit 2 shows parity fault of the character at FIFO head.
// - Bit 3 shows missing stop bit of the character at FIFO head.
// - Bit 4 set when line stays low for a whole character.
// - Break pushes one zero character, then waits for a valid start.
// - Bits 1 to 4 clear when software reads the status word.
// - Any of bits 1 to 4 raises the line status interrupt.
// - Bit 5 shows empty transmit FIFO, raises interrupt, clears on write.
// - Bit 6 high only when transmit FIFO and shifter are empty.
// - Bit 7 high while a faulty character is in FIFO; read clears.
// - Framing check looks at the first stop bit only.
// - FIFO clear empties the FIFO without disturbing the receiver.
module line_status (
	input  wire                clk_i,         // Core clock, 250 MHz
	input  wire                rst_i,         // Async reset, active high
	input  wire                ce_i,          // Clock enable
	input  wire                baud_tick_i,   // Sixteen times bit rate
	input  wire                rx_pad_i,      // Serial receive line
	input  wire [1:0]          char_len_i,    // Data bits minus five
	input  wire                parity_en_i,   // Parity checked
	input  wire                parity_even_i, // Even parity
	input  wire                parity_stick_i,// Stick parity
	input  wire                rx_clear_i,    // Receive FIFO clear pulse
	input  wire                rx_pop_i,      // Take head character
	output reg  [7:0]          rx_data_o,     // Head character
	output wire [`RXF_CW-1:0]  rx_count_o,    // Characters in FIFO
	input  wire                tx_fifo_mt_i,  // Transmit FIFO empty
	input  wire                tx_shift_mt_i, // Transmit shifter empty
	input  wire                tx_write_i,    // Software writes tx FIFO
	input  wire                status_read_i, // Status word read pulse
	output reg  [`LS_WIDTH-1:0] line_status_o, // Line status word
	output wire                rls_irq_o,     // Line status request
	output wire                thre_irq_o     // Tx holding empty request
);
	reg  [`ENTRY_W-1:0] mem [0:`RXF_DEPTH-1];
	reg  [`RXF_AW-1:0]  wr_ptr;
	reg  [`RXF_AW-1:0]  rd_ptr;
	reg  [`RXF_CW-1:0]  count;
	reg  [`RXF_CW-1:0]  err_count;
	reg  [2:0]          head_tag;
	reg  [2:0]          state;
	reg  [3:0]          tick_cnt;
	reg  [3:0]          bit_cnt;
	reg  [7:0]          shifter;
	reg                 all_zero;
	reg                 par_fault;
	reg                 sync1;
	reg                 sync2;
	reg                 char_valid;
	reg  [`ENTRY_W-1:0] char_entry;
	reg                 overrun;
	reg                 head_hide;
	reg                 err_hide;
	reg                 tx_mt;
	reg                 tx_idle;
	wire                buf_ready;
	wire                buf_valid;
	wire [`ENTRY_W-1:0] buf_data;
	wire                push;
	wire                pop;
	wire                sample;
	wire [`ENTRY_W-1:0] head;
	wire [`ENTRY_W-1:0] next_entry;
	wire                err_in;
	wire                err_out;
	wire                err_any;
	wire [3:0]          nbits;

	function parity_expect;
		input [7:0] data;
		input       even;
		input       stick;
		begin
			if (stick)
				parity_expect = ~even;
			else
				parity_expect = (^data) ^ ~even;
		end
	endfunction

	// Right-align a character shifted in LSB first from the top
	function [7:0] align;
		input [7:0] sh;
		input [1:0] len;
		begin
			align = sh >> (2'h3 - len);
		end
	endfunction

	function has_err;
		input [`ENTRY_W-1:0] e;
		begin
			has_err = e[`TAG_PARITY] | e[`TAG_FRAMING] | e[`TAG_BREAK];
		end
	endfunction

	assign nbits  = `MIN_BITS + {2'h0, char_len_i};
	assign sample = ce_i & baud_tick_i;

	// Receiver: pad is synchronised before any decision is made
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync1 <= 1'b1;
			sync2 <= 1'b1;
		end else if (ce_i) begin
			sync1 <= rx_pad_i;
			sync2 <= sync1;
		end
	end

	// Shift register stage is never touched by FIFO clear or overrun
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state      <= `RX_IDLE;
			tick_cnt   <= 4'h0;
			bit_cnt    <= 4'h0;
			shifter    <= 8'h00;
			all_zero   <= 1'b1;
			par_fault  <= 1'b0;
			char_valid <= 1'b0;
			char_entry <= {`ENTRY_W{1'b0}};
		end else if (ce_i) begin
			char_valid <= 1'b0;
			if (sample)
				tick_cnt <= tick_cnt + 4'h1;
			case (state)
			`RX_IDLE: begin
				tick_cnt <= 4'h0;
				if (!sync2)
					state <= `RX_START;
			end
			`RX_START: begin
				if (sample && tick_cnt == `OS_MID) begin
					tick_cnt  <= 4'h0;
					bit_cnt   <= 4'h0;
					all_zero  <= 1'b1;
					par_fault <= 1'b0;
					state     <= sync2 ? `RX_IDLE : `RX_DATA;
				end
			end
			`RX_DATA: begin
				if (sample && tick_cnt == `OS_LAST) begin
					shifter  <= {sync2, shifter[7:1]};
					all_zero <= all_zero & ~sync2;
					bit_cnt  <= bit_cnt + 4'h1;
					if (bit_cnt == nbits - 4'h1)
						state <= parity_en_i ? `RX_PARITY : `RX_STOP;
				end
			end
			`RX_PARITY: begin
				if (sample && tick_cnt == `OS_LAST) begin
					all_zero  <= all_zero & ~sync2;
					par_fault <= sync2 != parity_expect(
						align(shifter, char_len_i),
						parity_even_i, parity_stick_i);
					state <= `RX_STOP;
				end
			end
			`RX_STOP: begin
				// Only the first stop bit is looked at
				if (sample && tick_cnt == `OS_LAST) begin
					char_valid <= 1'b1;
					if (!sync2 && all_zero) begin
						char_entry <= {3'b100, 8'h00};
					end else begin
						char_entry <= {1'b0, ~sync2, par_fault,
							align(shifter, char_len_i)};
					end
					state <= sync2 ? `RX_IDLE : `RX_WAIT_HIGH;
				end
			end
			`RX_WAIT_HIGH: begin
				if (sync2)
					state <= `RX_IDLE;
			end
			default: state <= `RX_IDLE;
			endcase
		end
	end

	// A character finding no room is dropped and flagged
	rx_skid_buffer rx_skid_buffer_inst (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.ce_i        (ce_i),
		.flush_i     (rx_clear_i),
		.in_valid_i  (char_valid),
		.in_ready_o  (buf_ready),
		.in_data_i   (char_entry),
		.out_valid_o (buf_valid),
		.out_ready_i (count != `RXF_FULL),
		.out_data_o  (buf_data)
	);

	assign push       = buf_valid & (count != `RXF_FULL) & ~rx_clear_i;
	assign pop        = rx_pop_i & (count != {`RXF_CW{1'b0}}) & ~rx_clear_i;
	assign head       = mem[rd_ptr];
	assign next_entry = mem[rd_ptr + {{(`RXF_AW-1){1'b0}}, 1'b1}];
	assign err_in     = push & has_err(buf_data);
	assign err_out    = pop & has_err(head);
	assign rx_count_o = count;

	always @(posedge clk_i) begin
		if (ce_i && push)
			mem[wr_ptr] <= buf_data;
	end

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr    <= {`RXF_AW{1'b0}};
			rd_ptr    <= {`RXF_AW{1'b0}};
			count     <= {`RXF_CW{1'b0}};
			err_count <= {`RXF_CW{1'b0}};
		end else if (ce_i) begin
			if (rx_clear_i) begin
				wr_ptr    <= {`RXF_AW{1'b0}};
				rd_ptr    <= {`RXF_AW{1'b0}};
				count     <= {`RXF_CW{1'b0}};
				err_count <= {`RXF_CW{1'b0}};
			end else begin
				if (push)
					wr_ptr <= wr_ptr + {{(`RXF_AW-1){1'b0}}, 1'b1};
				if (pop)
					rd_ptr <= rd_ptr + {{(`RXF_AW-1){1'b0}}, 1'b1};
				if (push && !pop)
					count <= count + {{(`RXF_CW-1){1'b0}}, 1'b1};
				else if (pop && !push)
					count <= count - {{(`RXF_CW-1){1'b0}}, 1'b1};
				if (err_in && !err_out)
					err_count <= err_count + {{(`RXF_CW-1){1'b0}}, 1'b1};
				else if (err_out && !err_in)
					err_count <= err_count - {{(`RXF_CW-1){1'b0}}, 1'b1};
			end
		end
	end

	assign err_any = (err_count != {`RXF_CW{1'b0}});

	// Head copy lags the FIFO by one cycle, except that a pop loads the next entry at once, so outputs come from flops
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_data_o <= 8'h00;
			head_tag  <= 3'h0;
		end else if (ce_i) begin
			if (count == {`RXF_CW{1'b0}} || rx_clear_i) begin
				rx_data_o <= 8'h00;
				head_tag  <= 3'h0;
			end else if (pop) begin
				rx_data_o <= next_entry[7:0];
				head_tag  <= (count == {{(`RXF_CW-1){1'b0}}, 1'b1}) ? 3'h0 :
					next_entry[`TAG_BREAK:`TAG_PARITY];
			end else begin
				rx_data_o <= head[7:0];
				head_tag  <= head[`TAG_BREAK:`TAG_PARITY];
			end
		end
	end

	// Sticky flags: a new event in the read cycle wins over the clear
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			overrun   <= 1'b0;
			head_hide <= 1'b0;
			err_hide  <= 1'b0;
			tx_mt     <= 1'b1;
			tx_idle   <= 1'b1;
		end else if (ce_i) begin
			if (char_valid && !buf_ready)
				overrun <= 1'b1;
			else if (status_read_i)
				overrun <= 1'b0;
			// A new head shows its own tags again
			if (pop || rx_clear_i || (push && count == {`RXF_CW{1'b0}}))
				head_hide <= 1'b0;
			else if (status_read_i)
				head_hide <= 1'b1;
			if (err_in)
				err_hide <= 1'b0;
			else if (status_read_i)
				err_hide <= 1'b1;
			tx_mt   <= tx_fifo_mt_i & ~tx_write_i;
			tx_idle <= tx_fifo_mt_i & tx_shift_mt_i & ~tx_write_i;
		end
	end

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			line_status_o <= `LS_RESET;
		end else if (ce_i) begin
			line_status_o[`LS_DATA_AVAIL] <=
				(count != {`RXF_CW{1'b0}});
			line_status_o[`LS_OVERRUN]    <= overrun;
			line_status_o[`LS_PARITY]     <=
				head_tag[0] & ~head_hide;
			line_status_o[`LS_FRAMING]    <=
				head_tag[1] & ~head_hide;
			line_status_o[`LS_BREAK]      <=
				head_tag[2] & ~head_hide;
			line_status_o[`LS_TX_FIFO_MT] <= tx_mt;
			line_status_o[`LS_TX_IDLE]    <= tx_idle;
			line_status_o[`LS_RX_ERR_ANY] <= err_any & ~err_hide;
		end
	end

	assign rls_irq_o  = |line_status_o[`LS_BREAK:`LS_OVERRUN];
	assign thre_irq_o = line_status_o[`LS_TX_FIFO_MT];
endmodule // line_status

// ==== tb/line_status_props.sv ====
// Assertions on the line status block ports
`timescale 1ns/1ps
module line_status_props (
	input wire       clk_i,
	input wire       rst_i,
	input wire       ce_i,
	input wire       baud_tick_i,
	input wire       rx_pad_i,
	input wire [1:0] char_len_i,
	input wire       parity_en_i,
	input wire       parity_even_i,
	input wire       parity_stick_i,
	input wire       rx_clear_i,
	input wire       rx_pop_i,
	input wire [7:0] rx_data_o,
	input wire [4:0] rx_count_o,
	input wire       tx_fifo_mt_i,
	input wire       tx_shift_mt_i,
	input wire       tx_write_i,
	input wire       status_read_i,
	input wire [7:0] line_status_o,
	input wire       rls_irq_o,
	input wire       thre_irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// A pop or clear may legally re-show tags, so only plain reads count
	sequence read_s;
		ce_i && status_read_i && !rx_pop_i && !rx_clear_i && rx_count_o != 0;
	endsequence
	sequence hidden_s;
		line_status_o[4:2] == 3'h0;
	endsequence
	// A frozen cycle leaves the status word one update behind the count
	property avail_p;
		$past(ce_i) |-> line_status_o[0] == ($past(rx_count_o) != 0);
	endproperty
	property write_p;
		ce_i && tx_write_i ##1 ce_i |=> !line_status_o[5];
	endproperty
	avail_flag_a: assert property (avail_p)
		else $error("data available flag wrong");
	read_clear_a: assert property (read_s ##1 ce_i |=> hidden_s)
		else $error("head flags not cleared by read");
	fifo_bound_a: assert property (rx_count_o <= 5'h10)
		else $error("fifo count beyond depth");
	rls_irq_a: assert property (rls_irq_o == |line_status_o[4:1])
		else $error("line status request wrong");
	thre_irq_a: assert property (thre_irq_o == line_status_o[5])
		else $error("holding empty request wrong");
	tx_write_a: assert property (write_p)
		else $error("tx fifo empty not cleared by write");
	tx_idle_a: assert property (line_status_o[6] |-> line_status_o[5])
		else $error("tx idle without empty fifo");
	rx_clear_a: assert property (ce_i && rx_clear_i |=> rx_count_o == 0)
		else $error("fifo not emptied by clear");
endmodule // line_status_props

// ==== tb/serial_tx_model.sv ====
// Remote serial transmitter driving the receive line
`timescale 1ns/1ps
module serial_tx_model (
	input  wire clk_i,       // Core clock
	input  wire baud_tick_i, // Sixteen ticks a bit
	output reg  line_o       // Serial line, idle high
);
	initial line_o = 1'b1;
	task wait_tick;
		begin
			@(posedge clk_i);
			while (baud_tick_i !== 1'b1)
				@(posedge clk_i);
		end
	endtask
	task bit_out(input v);
		begin
			#1 line_o = v;
			repeat (16) wait_tick;
		end
	endtask
	// Kind 0 clean, 1 parity flipped, 2 stop low, 3 break
	task send(input [7:0] d, input [1:0] len, input pen, input even,
		input stick, input [1:0] kind);
		integer i;
		reg p;
		begin
			p = stick ? ~even : (even ? ^d : ~^d);
			bit_out(1'b0);
			for (i = 0; i < 5 + len; i = i + 1)
				bit_out(kind == 2'h3 ? 1'b0 : d[i]);
			if (pen)
				bit_out(kind == 2'h3 ? 1'b0 : p ^ (kind == 2'h1));
			bit_out(kind < 2'h2);
			// Idle gap also lets a receiver stuck on a low stop recover
			bit_out(1'b1);
		end
	endtask
endmodule // serial_tx_model

// ==== tb/line_status_test.sv ====
// Self-checking bench for the line status block
`timescale 1ns/1ps
module line_status_test;
	reg clk_i = 1'b0, rst_i = 1'b1, baud_tick_i = 1'b0, ce_i = 1'b1;
	reg [1:0] char_len_i = 2'h3;
	reg parity_en_i = 1'b0, parity_even_i = 1'b0, parity_stick_i = 1'b0;
	reg rx_clear_i = 1'b0, rx_pop_i = 1'b0, tx_write_i = 1'b0;
	reg status_read_i = 1'b0, tx_fifo_mt_i = 1'b1, tx_shift_mt_i = 1'b1;
	wire rx_pad_i, rls_irq_o, thre_irq_o;
	wire [7:0] rx_data_o, line_status_o;
	wire [4:0] rx_count_o;
	integer fail_count = 0, compares = 0, cycles = 0, i, seed;
	reg [10:0] q[$];
	reg [10:0] e;
	reg [7:0] d;
	always #2 clk_i = ~clk_i;
	always @(posedge clk_i) baud_tick_i <= #1 ~baud_tick_i;
	always @(posedge clk_i) begin
		cycles = cycles + 1;
		if (cycles == 40000) begin
			fail_count = fail_count + 1;
			end_of_test;
		end
	end
	line_status line_status_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.baud_tick_i(baud_tick_i), .rx_pad_i(rx_pad_i),
		.char_len_i(char_len_i), .parity_en_i(parity_en_i),
		.parity_even_i(parity_even_i), .parity_stick_i(parity_stick_i),
		.rx_clear_i(rx_clear_i), .rx_pop_i(rx_pop_i), .rx_data_o(rx_data_o),
		.rx_count_o(rx_count_o), .tx_fifo_mt_i(tx_fifo_mt_i),
		.tx_shift_mt_i(tx_shift_mt_i), .tx_write_i(tx_write_i),
		.status_read_i(status_read_i), .line_status_o(line_status_o),
		.rls_irq_o(rls_irq_o), .thre_irq_o(thre_irq_o));
	serial_tx_model serial_tx_model_inst (.clk_i(clk_i),
		.baud_tick_i(baud_tick_i), .line_o(rx_pad_i));
	task tick(input integer n);
		begin
			repeat (n) @(posedge clk_i);
			#1;
		end
	endtask
	task chk(input [10:0] got, input [10:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("[ERR] %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task strobe(input [3:0] s);
		begin
			{tx_write_i, rx_clear_i, status_read_i, rx_pop_i} = s;
			tick(1);
			{tx_write_i, rx_clear_i, status_read_i, rx_pop_i} = 4'h0;
		end
	endtask
	function [10:0] expect_entry(input [7:0] dd, input [1:0] kind);
		expect_entry = kind == 2'h3 ? 11'h400 :
			{1'b0, kind == 2'h2, kind == 2'h1 && parity_en_i, dd};
	endfunction
	task frame(input [1:0] kind);
		begin
			d = $urandom & (8'hff >> (2'h3 - char_len_i));
			// A low stop after all-zero bits would read as a break
			if (kind == 2'h2)
				d = d | 8'h01;
			serial_tx_model_inst.send(d, char_len_i, parity_en_i,
				parity_even_i, parity_stick_i, kind);
			e = expect_entry(d, kind);
			tick(4);
		end
	endtask
	task drain;
		begin
			while (q.size() != 0) begin
				e = q.pop_front();
				chk(rx_data_o, e[7:0]);
				strobe(4'h1);
				tick(2);
			end
			chk(line_status_o[0], 1'b0);
		end
	endtask
	task end_of_test;
		begin
			$display("Compares %0d, mismatches %0d", compares, fail_count);
			if (fail_count == 0 && compares > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	initial begin
		seed = $urandom(35706);
		tick(12);
		chk(line_status_o, 8'h60);
		rst_i = 1'b0;
		for (i = 0; i < 8; i = i + 1) begin
			{char_len_i, parity_even_i, parity_stick_i} = $urandom;
			parity_en_i = (i % 4 == 1) | $urandom;
			frame(i % 4);
			chk(line_status_o[4:0], {e[10:8], 2'h1});
			chk(line_status_o[7], |e[10:8]);
			chk({rls_irq_o, thre_irq_o}, {|e[10:8], 1'b1});
			strobe(4'h2);
			tick(1);
			chk(line_status_o, 8'h61);
			chk(rls_irq_o, 1'b0);
			q.push_back(e);
			drain;
		end
		char_len_i = 2'h3;
		parity_en_i = 1'b0;
		// Sixteen in the fifo plus two buffered, then one too many
		for (i = 0; i < 19; i = i + 1) begin
			frame(2'h0);
			if (i < 18)
				q.push_back(e);
			chk(line_status_o[1], i == 18);
		end
		chk(rx_count_o, 5'h10);
		strobe(4'h2);
		tick(1);
		chk(line_status_o[1], 1'b0);
		drain;
		frame(2'h0);
		fork
			frame(2'h0);
			begin
				tick(100);
				strobe(4'h4);
			end
		join
		q.push_back(e);
		chk(rx_count_o, 5'h01);
		drain;
		for (i = 0; i < 4; i = i + 1) begin
			{tx_shift_mt_i, tx_fifo_mt_i} = i;
			tick(3);
			chk(line_status_o[6:5], {i == 3, i[0]});
			strobe(4'h8);
			tick(1);
			chk(line_status_o[6:5], 2'h0);
		end
		// A read of an empty FIFO must not hide the next head's flags
		strobe(4'h2);
		parity_en_i = 1'b1;
		frame(2'h1);
		chk(line_status_o[4:0], {e[10:8], 2'h1});
		// Enable low: a pop strobe must leave the FIFO untouched
		ce_i = 1'b0;
		strobe(4'h1);
		tick(2);
		ce_i = 1'b1;
		chk(rx_count_o, 5'h01);
		chk(rx_data_o, e[7:0]);
		// Reset in mid-run drops the held character
		rst_i = 1'b1;
		tick(1);
		chk(line_status_o, 8'h60);
		chk(rx_count_o, 5'h00);
		chk(rx_data_o, 8'h00);
		rst_i = 1'b0;
		tick(2);
		chk(line_status_o, 8'h60);
		end_of_test;
	end
endmodule // line_status_test
bind line_status line_status_props line_status_props_inst (.clk_i(clk_i),
	.rst_i(rst_i), .ce_i(ce_i), .baud_tick_i(baud_tick_i),
	.rx_pad_i(rx_pad_i), .char_len_i(char_len_i), .parity_en_i(parity_en_i),
	.parity_even_i(parity_even_i), .parity_stick_i(parity_stick_i),
	.rx_clear_i(rx_clear_i), .rx_pop_i(rx_pop_i), .rx_data_o(rx_data_o),
	.rx_count_o(rx_count_o), .tx_fifo_mt_i(tx_fifo_mt_i),
	.tx_shift_mt_i(tx_shift_mt_i), .tx_write_i(tx_write_i),
	.status_read_i(status_read_i), .line_status_o(line_status_o),
	.rls_irq_o(rls_irq_o), .thre_irq_o(thre_irq_o));
